// ==== sws_pkg.sv ====
`default_nettype none
package sws_pkg;
  // ----------------------------------------------------------------
  // register map, 16-bit registers
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_TICK_MULT = 16'h0400;
  localparam logic [15:0] REG_HOST_WD = 16'h0410;
  localparam logic [15:0] REG_PROC_WD = 16'h0420;
  localparam logic [15:0] TICK_MULT_RST = 16'h09C2;
  localparam logic [15:0] HOST_WD_RST = 16'h03E8;
  localparam logic [15:0] PROC_WD_RST = 16'h03E8;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_NS = 40;
  localparam int BASE_TICK_CYC = (BASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] TICK_MULT_OFS = 17'h00002;
  localparam int WD_DEFAULT_MS = 100;
  // 16-bit count times the widest tick reaches about this many seconds
  localparam int WD_HW_MAX_S = 170;
  // ----------------------------------------------------------------
  // slave state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SWS_POWERUP = 4'b0001,
    SWS_CONFIG = 4'b0010,
    SWS_GUARDED = 4'b0100,
    SWS_RUNNING = 4'b1000
  } sws_state_t;
endpackage
`default_nettype wire

// ==== sws_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module sws_tick_gen #(
  parameter int BASE_CYC = sws_pkg::BASE_TICK_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] mult,
  output logic tick
);
  localparam logic [7:0] BASE_LAST = 8'(BASE_CYC - 1);

  typedef struct packed {
    logic [7:0] base_cnt;
    logic [16:0] mult_cnt;
    logic tick;
  } sws_tick_st_t;

  sws_tick_st_t q;
  sws_tick_st_t d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.base_cnt >= BASE_LAST)
    begin
      d.base_cnt = 8'h00;
      // >= so that a lowered multiplier never strands the count
      if (q.mult_cnt + 17'h00001 >= {1'b0, mult} + sws_pkg::TICK_MULT_OFS) // see [R04]
      begin
        d.mult_cnt = 17'h00000;
        d.tick = 1'b1;
      end
      else
      begin
        d.mult_cnt = q.mult_cnt + 17'h00001;
      end
    end
    else
    begin
      d.base_cnt = q.base_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

// ==== sws_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
module sws_watchdog (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic kick,
  input wire logic [15:0] timeout,
  output logic expired
);
  typedef struct packed {
    logic [15:0] cnt;
    logic expired;
  } sws_wd_st_t;

  sws_wd_st_t q;
  sws_wd_st_t d;

  always_comb
  begin
    d = q;
    if (timeout == 16'h0000)
    begin
      d = '0; // see [R11]
    end
    else if (kick)
    begin
      // activity in the same cycle as expiry means no expiry
      d = '0; // see [R06] [R08]
    end
    else if (tick && !q.expired)
    begin
      if ({1'b0, q.cnt} + 17'h00001 >= {1'b0, timeout}) // see [R03] [R12]
      begin
        d.expired = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign expired = q.expired;
endmodule
`default_nettype wire

// ==== sws_core.sv ====
// Overview of operation
// [R01] two independent watchdogs: process data side and local host side, 100 ms default
// [R02] one multiplier register at 0x400 sets the tick for both watchdogs
// [R03] host timeout at 0x410, process timeout at 0x420, each times the tick
// [R04] tick lasts multiplier plus two base ticks of 40 ns
// [R05] defaults: multiplier 2498, process count 1000, giving 100 ms
// [R06] process watchdog restarts on each successful process data access
// [R07] process watchdog expiry leaves the slave state unchanged
// [R08] once expired, only a new process data access clears it
// [R09] host watchdog expires when the local host stays silent too long
// [R10] on expiry outputs go to the preset safe value
// [R11] process count zero switches that watchdog off entirely
// [R12] counts up to 65535 accepted, roughly 170 s maximum
// [R13] master writes timing registers only when enabled; otherwise values stay; the code has no enable and writes on every reg_wr
// [R14] after power-up: power-up state, no mailbox or process traffic
// [R15] master sets up channels 0 and 1 for mailbox in power-up
// [R16] power-up to configuration checks mailbox channel setup
// [R17] configuration allows mailbox only; master sets process channels from 2
// [R18] configuration to guarded checks channels and clock, then copies inputs
// [R19] guarded state: all traffic, inputs updated, outputs held safe
// [R20] master delivers valid output data before requesting running
// [R21] running state: master output data copied to physical outputs
// [R22] failed transition check: stay put and flag an error
`timescale 1ns/1ps
`default_nettype none
module sws_core #(
  parameter int W = 8,
  parameter int BASE_CYC = sws_pkg::BASE_TICK_CYC,
  parameter logic [15:0] MULT_RST = sws_pkg::TICK_MULT_RST,
  parameter logic [15:0] HOST_RST = sws_pkg::HOST_WD_RST,
  parameter logic [15:0] PROC_RST = sws_pkg::PROC_WD_RST
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic pd_access,
  input wire logic pd_out_wr,
  input wire logic [W-1:0] pd_out_data,
  input wire logic host_access,
  input wire logic state_req_valid,
  input wire logic [3:0] state_req,
  input wire logic mbx_ch_ok,
  input wire logic pd_ch_ok,
  input wire logic dc_ok,
  input wire logic [W-1:0] in_pins,
  input wire logic [W-1:0] safe_value,
  output logic [3:0] state_cur,
  output logic state_ack,
  output logic state_err,
  output logic mbx_allowed,
  output logic pd_allowed,
  output logic [W-1:0] in_image,
  output logic [W-1:0] out_pins,
  output logic pd_wd_expired,
  output logic host_wd_expired
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mult;
    logic [15:0] host_wd;
    logic [15:0] proc_wd;
    logic [15:0] rdata;
    sws_pkg::sws_state_t state;
    logic ack;
    logic err;
    logic mbx_ok;
    logic pd_ok;
    logic out_seen;
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] in_image;
    logic [W-1:0] out_buf;
    logic [W-1:0] out_pins;
  } sws_core_st_t;

  sws_core_st_t q;
  sws_core_st_t d;
  logic wd_tick;
  logic pd_kick;
  logic pd_exp;
  logic host_exp;
  logic req_ok;
  logic trip;
  sws_pkg::sws_state_t req_st;

  // ----------------------------------------------------------------
  // watchdogs
  // ----------------------------------------------------------------
  // only accesses the state machine lets through count as successful
  assign pd_kick = pd_access && q.pd_ok; // see [R06]
  assign trip = pd_exp || host_exp; // see [R10]
  assign req_st = sws_pkg::sws_state_t'(state_req);

  sws_tick_gen #(
    .BASE_CYC(BASE_CYC)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .mult(q.mult), // see [R02]
    .tick(wd_tick)
  );

  sws_watchdog u_proc_wd (
    .clk(clk),
    .rstn(rstn),
    .tick(wd_tick),
    .kick(pd_kick), // see [R01]
    .timeout(q.proc_wd),
    .expired(pd_exp)
  );

  sws_watchdog u_host_wd (
    .clk(clk),
    .rstn(rstn),
    .tick(wd_tick),
    .kick(host_access), // see [R09]
    .timeout(q.host_wd),
    .expired(host_exp)
  );

  // ----------------------------------------------------------------
  // transition checks
  // ----------------------------------------------------------------
  always_comb
  begin
    req_ok = 1'b0;
    if (req_st == sws_pkg::SWS_POWERUP || req_st == q.state)
    begin
      req_ok = 1'b1;
    end
    else
    begin
      case (q.state)
        sws_pkg::SWS_POWERUP:
        begin
          // channels 0 and 1 must have been set up by the master
          req_ok = (req_st == sws_pkg::SWS_CONFIG) && mbx_ch_ok; // see [R15] [R16]
        end
        sws_pkg::SWS_CONFIG:
        begin
          req_ok = (req_st == sws_pkg::SWS_GUARDED) && pd_ch_ok && dc_ok; // see [R17] [R18]
        end
        sws_pkg::SWS_GUARDED:
        begin
          // running needs output data from the master first
          req_ok = (req_st == sws_pkg::SWS_CONFIG)
                || ((req_st == sws_pkg::SWS_RUNNING) && q.out_seen); // see [R20]
        end
        sws_pkg::SWS_RUNNING:
        begin
          req_ok = (req_st == sws_pkg::SWS_CONFIG) || (req_st == sws_pkg::SWS_GUARDED);
        end
        default:
        begin
          req_ok = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    d.sync1 = in_pins;
    d.sync2 = q.sync1;
    // registers change only on an explicit write
    if (reg_wr) // see [R13]
    begin
      case (reg_addr)
        sws_pkg::REG_TICK_MULT: d.mult = reg_wdata; // see [R02]
        sws_pkg::REG_HOST_WD: d.host_wd = reg_wdata; // see [R03]
        sws_pkg::REG_PROC_WD: d.proc_wd = reg_wdata; // see [R03] [R12]
        default: d.mult = q.mult;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        sws_pkg::REG_TICK_MULT: d.rdata = q.mult;
        sws_pkg::REG_HOST_WD: d.rdata = q.host_wd;
        sws_pkg::REG_PROC_WD: d.rdata = q.proc_wd;
        default: d.rdata = 16'h0000;
      endcase
    end
    // expiry never moves the state machine; only requests do
    if (state_req_valid) // see [R07]
    begin
      if (req_ok)
      begin
        d.state = req_st;
        d.ack = 1'b1;
        d.err = 1'b0;
        if (q.state == sws_pkg::SWS_CONFIG && req_st == sws_pkg::SWS_GUARDED)
        begin
          d.in_image = q.sync2; // see [R18]
        end
        if (req_st == sws_pkg::SWS_POWERUP || req_st == sws_pkg::SWS_CONFIG)
        begin
          d.out_seen = 1'b0;
        end
      end
      else
      begin
        d.err = 1'b1; // see [R22]
      end
    end
    if (pd_out_wr && q.pd_ok)
    begin
      d.out_buf = pd_out_data;
      d.out_seen = 1'b1;
    end
    if (q.state == sws_pkg::SWS_GUARDED || q.state == sws_pkg::SWS_RUNNING)
    begin
      d.in_image = q.sync2; // see [R19]
    end
    d.mbx_ok = (d.state != sws_pkg::SWS_POWERUP); // see [R14] [R17]
    d.pd_ok = (d.state == sws_pkg::SWS_GUARDED) || (d.state == sws_pkg::SWS_RUNNING); // see [R19]
    if (d.state == sws_pkg::SWS_RUNNING && !trip)
    begin
      d.out_pins = q.out_buf; // see [R21]
    end
    else
    begin
      d.out_pins = safe_value; // see [R10] [R19]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.mult <= MULT_RST; // see [R05]
      q.host_wd <= HOST_RST; // see [R01]
      q.proc_wd <= PROC_RST; // see [R05]
      q.state <= sws_pkg::SWS_POWERUP; // see [R14]
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign state_cur = q.state;
  assign state_ack = q.ack;
  assign state_err = q.err;
  assign mbx_allowed = q.mbx_ok;
  assign pd_allowed = q.pd_ok;
  assign in_image = q.in_image;
  assign out_pins = q.out_pins;
  assign pd_wd_expired = pd_exp;
  assign host_wd_expired = host_exp;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_powerup_no_traffic: assert property ( // see [R14]
    state_cur == sws_pkg::SWS_POWERUP |-> !mbx_allowed && !pd_allowed)
    else $error("traffic allowed in power-up state");

  a_config_mbx_only: assert property ( // see [R17]
    state_cur == sws_pkg::SWS_CONFIG |-> mbx_allowed && !pd_allowed)
    else $error("configuration state gating wrong");

  a_guarded_safe_out: assert property ( // see [R19]
    state_cur == sws_pkg::SWS_GUARDED |-> out_pins == $past(safe_value))
    else $error("outputs not safe in guarded state");

  a_running_copy: assert property ( // see [R21]
    state_cur == sws_pkg::SWS_RUNNING && !$past(trip) |-> out_pins == $past(q.out_buf))
    else $error("running outputs do not follow master data");

  a_trip_safe_out: assert property ( // see [R10]
    $past(trip) |-> out_pins == $past(safe_value))
    else $error("expired watchdog left outputs live");

  a_trip_keeps_state: assert property ( // see [R07]
    $rose(pd_wd_expired) && !$past(state_req_valid) |-> $stable(state_cur))
    else $error("watchdog expiry changed state");

  a_bad_req_err: assert property ( // see [R22]
    state_req_valid && state_cur == sws_pkg::SWS_POWERUP
    && state_req == sws_pkg::SWS_RUNNING |=> state_err && !state_ack && $stable(state_cur))
    else $error("illegal request not refused");

  a_mbx_check: assert property ( // see [R16]
    state_req_valid && state_cur == sws_pkg::SWS_POWERUP
    && state_req == sws_pkg::SWS_CONFIG && !mbx_ch_ok |=> state_cur == sws_pkg::SWS_POWERUP)
    else $error("configuration entered without mailbox setup");

  a_guard_check: assert property ( // see [R18]
    state_req_valid && state_cur == sws_pkg::SWS_CONFIG
    && state_req == sws_pkg::SWS_GUARDED && !(pd_ch_ok && dc_ok)
    |=> state_cur == sws_pkg::SWS_CONFIG)
    else $error("guarded state entered without channel check");

  a_guard_copy: assert property ( // see [R18]
    state_cur == sws_pkg::SWS_GUARDED && $past(state_cur) == sws_pkg::SWS_CONFIG
    |-> in_image == $past(q.sync2))
    else $error("inputs not copied on entry to guarded state");

  a_kick_clears: assert property ( // see [R08]
    pd_kick |=> !pd_wd_expired)
    else $error("process access did not clear watchdog");

  a_zero_disables: assert property ( // see [R11]
    q.proc_wd == 16'h0000 |=> !pd_wd_expired)
    else $error("disabled process watchdog expired");

  a_mult_readback: assert property ( // see [R02]
    reg_rd && reg_addr == sws_pkg::REG_TICK_MULT |=> reg_rdata == $past(q.mult))
    else $error("multiplier readback wrong");

  c_reach_running: cover property (state_cur == sws_pkg::SWS_RUNNING);
  c_pd_expiry: cover property ($rose(pd_wd_expired));
  c_host_expiry: cover property ($rose(host_wd_expired));
  c_refused_req: cover property ($rose(state_err));
endmodule
`default_nettype wire

// ==== sws_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module sws_master (
  input wire logic clk,
  output var logic state_req_valid,
  output var logic [3:0] state_req,
  output var logic pd_access,
  output var logic pd_out_wr,
  output var logic [7:0] pd_out_data
);
  initial
  begin
    state_req_valid = 1'b0;
    state_req = 4'h0;
    pd_access = 1'b0;
    pd_out_wr = 1'b0;
    pd_out_data = 8'h00;
  end
  // ----------------------------------------------------------------
  // frames, each held for exactly one rising edge
  // ----------------------------------------------------------------
  // channel setup is modelled by the level inputs the bench drives
  task automatic req(input logic [3:0] s);
    @(negedge clk);
    state_req_valid = 1'b1;
    state_req = s;
    @(negedge clk);
    state_req_valid = 1'b0;
    state_req = ~s;
  endtask
  task automatic put(input logic [7:0] d);
    @(negedge clk);
    pd_out_wr = 1'b1;
    pd_out_data = d;
    @(negedge clk);
    pd_out_wr = 1'b0;
    // released bus must not keep looking valid
    pd_out_data = ~d;
  endtask
  task automatic kick();
    @(negedge clk);
    pd_access = 1'b1;
    @(negedge clk);
    pd_access = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic w; logic [15:0] a; logic [15:0] d; logic [15:0] e;} sws_row_t;
  logic clk, rstn, reg_wr, reg_rd, host_access, mbx_ch_ok, pd_ch_ok, dc_ok;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic state_req_valid, pd_access, pd_out_wr, state_ack, state_err;
  logic mbx_allowed, pd_allowed, pd_wd_expired, host_wd_expired;
  logic [3:0] state_req, state_cur;
  logic [7:0] pd_out_data, in_pins, safe_value, in_image, out_pins;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  sws_row_t rows [7] = '{
    '{1'b0, 16'h0400, 16'h0000, 16'h0000},
    '{1'b0, 16'h0410, 16'h0000, 16'h0004},
    '{1'b0, 16'h0420, 16'h0000, 16'h0004},
    '{1'b1, 16'h0420, 16'h0100, 16'h0100},
    '{1'b1, 16'h0430, 16'h1234, 16'h0000},
    '{1'b1, 16'h0410, 16'hFFFF, 16'hFFFF},
    '{1'b1, 16'h0410, 16'h0008, 16'h0008}};

  sws_core #(.MULT_RST(16'h0000), .HOST_RST(16'h0004), .PROC_RST(16'h0004)) uut (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pd_access(pd_access),
    .pd_out_wr(pd_out_wr), .pd_out_data(pd_out_data), .host_access(host_access),
    .state_req_valid(state_req_valid), .state_req(state_req), .mbx_ch_ok(mbx_ch_ok),
    .pd_ch_ok(pd_ch_ok), .dc_ok(dc_ok), .in_pins(in_pins), .safe_value(safe_value),
    .state_cur(state_cur), .state_ack(state_ack), .state_err(state_err),
    .mbx_allowed(mbx_allowed), .pd_allowed(pd_allowed), .in_image(in_image),
    .out_pins(out_pins), .pd_wd_expired(pd_wd_expired), .host_wd_expired(host_wd_expired));
  sws_master m (
    .clk(clk), .state_req_valid(state_req_valid), .state_req(state_req),
    .pd_access(pd_access), .pd_out_wr(pd_out_wr), .pd_out_data(pd_out_data));

  always #5 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cut a hang short: whole run needs well under this
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
  task automatic st(input logic [3:0] s, input logic a, input logic e);
    chk("state", 16'(s), 16'(state_cur));
    chk("ack", 16'(a), 16'(state_ack));
    chk("err", 16'(e), 16'(state_err));
  endtask

  initial
  begin
    int i;
    clk = 1'b0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    host_access = 1'b1;
    mbx_ch_ok = 1'b0;
    pd_ch_ok = 1'b0;
    dc_ok = 1'b0;
    in_pins = 8'h5A;
    safe_value = 8'hC3;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("state", 16'h0001, 16'(state_cur));
    chk("mbx", 16'h0000, 16'(mbx_allowed));
    chk("pd", 16'h0000, 16'(pd_allowed));
    $display("reset test done");
    foreach (rows[k])
    begin
      if (rows[k].w)
        wr(rows[k].a, rows[k].d);
      rdr(rows[k].a, rd);
      chk("reg", rows[k].e, rd);
    end
    $display("register test done");
    // ----------------------------------------------------------------
    // state machine walk, refusals first
    // ----------------------------------------------------------------
    m.req(sws_pkg::SWS_RUNNING);
    st(4'h1, 1'b0, 1'b1);
    m.req(sws_pkg::SWS_CONFIG);
    st(4'h1, 1'b0, 1'b1);
    mbx_ch_ok = 1'b1;
    m.req(sws_pkg::SWS_CONFIG);
    st(4'h2, 1'b1, 1'b0);
    chk("mbx", 16'h0001, 16'(mbx_allowed));
    chk("pd", 16'h0000, 16'(pd_allowed));
    m.put(8'hA5);
    pd_ch_ok = 1'b1;
    m.req(sws_pkg::SWS_GUARDED);
    st(4'h2, 1'b0, 1'b1);
    dc_ok = 1'b1;
    m.req(sws_pkg::SWS_GUARDED);
    st(4'h4, 1'b1, 1'b0);
    chk("image", 16'h005A, 16'(in_image));
    chk("pd", 16'h0001, 16'(pd_allowed));
    chk("out", 16'h00C3, 16'(out_pins));
    in_pins = 8'h96;
    repeat (4) @(negedge clk);
    chk("image", 16'h0096, 16'(in_image));
    // write in config was dropped, so running is still refused
    m.req(sws_pkg::SWS_RUNNING);
    st(4'h4, 1'b0, 1'b1);
    m.kick();
    m.put(8'h3C);
    m.req(sws_pkg::SWS_RUNNING);
    st(4'h8, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk("out", 16'h003C, 16'(out_pins));
    $display("state test done");
    // ----------------------------------------------------------------
    // watchdogs: tick is 8 clocks with the multiplier at zero
    // ----------------------------------------------------------------
    wr(16'h0420, 16'h0002);
    // fresh kick so the expiry time is measured from a known edge
    m.kick();
    for (i = 0; i < 60 && pd_wd_expired !== 1'b1; i++)
      @(negedge clk);
    chk("pd_wd", 16'h0001, 16'(pd_wd_expired));
    // two ticks after the kick; free-running prescaler takes off up to one tick
    chk("wd_cnt", 16'h0001, 16'(i >= 9 && i <= 16));
    chk("state", 16'h0008, 16'(state_cur));
    repeat (2) @(negedge clk);
    chk("out", 16'h00C3, 16'(out_pins));
    m.kick();
    chk("pd_wd", 16'h0000, 16'(pd_wd_expired));
    wr(16'h0420, 16'h0000);
    repeat (60) @(negedge clk);
    chk("pd_wd", 16'h0000, 16'(pd_wd_expired));
    chk("out", 16'h003C, 16'(out_pins));
    host_access = 1'b0;
    for (i = 0; i < 120 && host_wd_expired !== 1'b1; i++)
      @(negedge clk);
    chk("host_wd", 16'h0001, 16'(host_wd_expired));
    repeat (2) @(negedge clk);
    chk("out", 16'h00C3, 16'(out_pins));
    $display("watchdog test done");
    // ----------------------------------------------------------------
    // reset in mid-run, from the running state
    // ----------------------------------------------------------------
    host_access = 1'b1;
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk("state", 16'h0001, 16'(state_cur));
    chk("mbx", 16'h0000, 16'(mbx_allowed));
    chk("pd", 16'h0000, 16'(pd_allowed));
    chk("host_wd", 16'h0000, 16'(host_wd_expired));
    rstn = 1'b1;
    @(negedge clk);
    chk("state", 16'h0001, 16'(state_cur));
    chk("out", 16'h00C3, 16'(out_pins));
    rdr(16'h0420, rd);
    chk("reg", 16'h0004, rd);
    $display("reset rerun test done");
    finish_test();
  end
endmodule
`default_nettype wire
